// ---- hw/tmps_pkg.sv ----
package tmps_pkg;
  // variant: 1'b0 narrow (16/32-bit halves), 1'b1 wide (32/64-bit)
  localparam bit IS_WIDE = 1'b0;
  localparam int HALF_W = IS_WIDE ? 32 : 16; // one half counter
  localparam int PS_W = IS_WIDE ? 16 : 8; // prescale and prescale match
  localparam int FULL_W = 2 * HALF_W; // combined counter
  localparam int EXT_W = HALF_W + PS_W; // half plus prescaler
  localparam int MODE_W = 3;
  localparam int SYNC_W = 24; // one select per half, 12 timers
  localparam int ADDR_W = 8;
  localparam logic [FULL_W-1:0] CNT_ONE = {{(FULL_W-1){1'b0}}, 1'b1};
  localparam logic [FULL_W-1:0] CNT_ZERO = {FULL_W{1'b0}};
  localparam logic [FULL_W-1:0] CNT_ALL = {FULL_W{1'b1}};
  localparam logic [FULL_W-1:0] EXT_MASK =
    {{(FULL_W-EXT_W){1'b0}}, {EXT_W{1'b1}}};

  // counting modes; codes 5..7 are illegal and stop the half
  typedef enum logic [MODE_W-1:0] {
    MODE_ONESHOT, MODE_PERIODIC, MODE_RTC, MODE_CAPCNT, MODE_PWM
  } tmps_mode_e;

  // control register bit positions
  localparam int CFG_SPLIT = 0; // 1: two half-width timers
  localparam int CFG_MODE_A = 1; // 3-bit field
  localparam int CFG_UP_A = 4;
  localparam int CFG_MODE_B = 5; // 3-bit field
  localparam int CFG_UP_B = 8;
  localparam int CFG_EN_A = 9;
  localparam int CFG_EN_B = 10;
  localparam int CFG_RTC_EN = 11;
  localparam int CFG_LDT_A = 12; // load update select, first half
  localparam int CFG_MTT_A = 13; // match update select, first half
  localparam int CFG_LDT_B = 14;
  localparam int CFG_MTT_B = 15;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic RELOAD_APPLY_NOW = 1'b0;
  localparam logic COMPARE_APPLY_NOW = 1'b0;

  // sync select bits; this module is narrow timer 0
  localparam int NARROW0_FIRST_HALF_SYNC_SELECT = 0;
  localparam int NARROW0_SECOND_HALF_SYNC_SELECT = 1;
  localparam int WIDE0_FIRST_HALF_SYNC_SELECT = 12;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LOAD_A = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LOAD_B = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MATCH_A = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_MATCH_B = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PSL_A = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_PSL_B = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_PSM_A = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_PSM_B = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_VAL_A = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_VAL_B = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_SYNC = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_VAL_AH = 8'h34;
endpackage

// ---- hw/tmps_half.sv ----
`timescale 1ns/1ns
module tmps_half (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic run, // half enabled
  input wire logic up_cfg, // software count direction
  input wire tmps_pkg::tmps_mode_e mode, // counting mode
  input wire logic rtc_en, // rtc count enable
  input wire logic cap_edge, // synchronised capture edge
  input wire logic restart, // sync restart pulse
  input wire logic defer_load, // load waits for timeout
  input wire logic defer_match, // match waits for timeout
  input wire logic ld_wr, // new load value pulse
  input wire logic [tmps_pkg::FULL_W-1:0] ld_val, // extended load
  input wire logic mt_wr, // new match value pulse
  input wire logic [tmps_pkg::FULL_W-1:0] mt_val, // extended match
  input wire logic [tmps_pkg::FULL_W-1:0] wmask, // counter width
  output logic [tmps_pkg::FULL_W-1:0] count_o, // counter value
  output logic match_o, // match event pulse
  output logic tmo_o, // timeout pulse
  output logic pwm_o // pwm level
);
  typedef struct packed {
    logic [tmps_pkg::FULL_W-1:0] cnt; // running count
    logic [tmps_pkg::FULL_W-1:0] load; // active load
    logic [tmps_pkg::FULL_W-1:0] match; // active compare
    logic [tmps_pkg::FULL_W-1:0] ld_pv; // buffered load
    logic [tmps_pkg::FULL_W-1:0] mt_pv; // buffered match
    logic ld_pend; // buffered load waiting
    logic mt_pend; // buffered match waiting
    logic done; // one-shot finished
    logic hit; // match event
    logic tmo; // timeout event
    logic pwm; // pwm output
  } tmps_half_s;
  tmps_half_s s, n;
  logic up; // effective direction
  logic step; // mode permits a step
  logic tick; // counter moves this cycle
  logic tmo; // timeout this cycle

  // next state of the half
  always_comb begin
    n = s;
    up = (mode == tmps_pkg::MODE_RTC) ||
         (up_cfg && mode != tmps_pkg::MODE_PWM);
    unique case (mode)
      tmps_pkg::MODE_ONESHOT, tmps_pkg::MODE_PERIODIC,
      tmps_pkg::MODE_PWM: step = 1'b1;
      tmps_pkg::MODE_RTC: step = rtc_en;
      tmps_pkg::MODE_CAPCNT: step = cap_edge;
      default: step = 1'b0; // illegal code: hold
    endcase
    tick = run && !s.done && step;
    tmo = tick && (up ? s.cnt == s.load : s.cnt == tmps_pkg::CNT_ZERO);
    n.tmo = tmo;
    if (!run) begin
      n.done = 1'b0; // re-enable rearms one-shot
    end
    if (tmo) begin
      if (!up && s.ld_pend) begin
        n.load = s.ld_pv;
        n.ld_pend = 1'b0;
      end
      if (!up && s.mt_pend) begin
        n.match = s.mt_pv;
        n.mt_pend = 1'b0;
      end
      n.cnt = up ? tmps_pkg::CNT_ZERO : n.load;
      if (mode == tmps_pkg::MODE_ONESHOT) begin
        n.done = 1'b1;
        n.cnt = s.cnt; // one-shot parks at its end value
      end
    end else if (tick) begin
      n.cnt = (up ? s.cnt + tmps_pkg::CNT_ONE
                  : s.cnt - tmps_pkg::CNT_ONE) & wmask;
    end
    if (restart) begin
      n.cnt = up ? tmps_pkg::CNT_ZERO : n.load;
      n.done = 1'b0;
    end
    // deferral only while counting down
    if (ld_wr) begin
      if (defer_load && !up) begin
        n.ld_pv = ld_val;
        n.ld_pend = 1'b1;
      end else begin
        n.load = ld_val;
        n.ld_pend = 1'b0;
        if (!up) begin
          n.cnt = ld_val;
        end
      end
    end
    if (mt_wr) begin
      if (defer_match && !up) begin
        n.mt_pv = mt_val;
        n.mt_pend = 1'b1;
      end else begin
        n.match = mt_val;
        n.mt_pend = 1'b0;
      end
    end
    // flag lands with the count that equals the compare value
    n.hit = run && (n.cnt == n.match) && (n.cnt != s.cnt);
    // high while the count lies above the compare value
    n.pwm = run && mode == tmps_pkg::MODE_PWM && n.cnt > n.match;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign count_o = s.cnt;
  assign match_o = s.hit;
  assign tmo_o = s.tmo;
  assign pwm_o = s.pwm;

  property p_defer_load;
    @(posedge pclk) disable iff (!presetn)
    (tmo && !up && s.ld_pend && !ld_wr) |=> s.load == $past(s.ld_pv);
  endproperty
  a_defer_load: assert property (p_defer_load)
    else $error("buffered load not applied at timeout");
  property p_imm_load;
    @(posedge pclk) disable iff (!presetn)
    (ld_wr && !up && !defer_load) |=> s.cnt == $past(ld_val);
  endproperty
  a_imm_load: assert property (p_imm_load)
    else $error("immediate load did not reach counter");
  property p_hold_match;
    @(posedge pclk) disable iff (!presetn)
    (mt_wr && defer_match && !up && !(tmo && s.mt_pend))
      |=> s.match == $past(s.match) ##[1:300] 1'b1;
  endproperty
  a_hold_match: assert property (p_hold_match)
    else $error("deferred match applied early");
  property p_up_match;
    @(posedge pclk) disable iff (!presetn)
    (mt_wr && up) |=> s.match == $past(mt_val);
  endproperty
  a_up_match: assert property (p_up_match)
    else $error("up count match write was deferred");
  property p_rtc_stop;
    @(posedge pclk) disable iff (!presetn)
    (mode == tmps_pkg::MODE_RTC && !rtc_en && !restart)
      |=> s.cnt == $past(s.cnt);
  endproperty
  a_rtc_stop: assert property (p_rtc_stop)
    else $error("rtc counted while disabled");
  property p_hit;
    @(posedge pclk) disable iff (!presetn)
    s.hit |-> s.cnt == s.match && s.cnt != $past(s.cnt);
  endproperty
  a_hit: assert property (p_hit)
    else $error("match event without equal count");
  property p_pwm;
    @(posedge pclk) disable iff (!presetn)
    ($past(run) && $past(mode) == tmps_pkg::MODE_PWM)
      |-> s.pwm == (s.cnt > s.match);
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("pwm level does not follow compare");
endmodule

// ---- hw/tmps_top.sv ----
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
// Overview of operation
// - capture count mode compares edges against match
// - pwm duty set by match within load period
// - match events also in periodic and one-shot
// - prescaler acts only in half-width operation
// - prescaler low bits in down-counting one-shot and periodic, else high
// - prescale match joins match in same order
// - prescale match field 8 or 16 bits
// - prescale load field 8 or 16 bits
// - rtc mode stops while rtc enable clear
// - rtc enable matters only in rtc mode
// - sync control lives in first module only
// - sync request restarts every selected counter together
// - full width: second half select ignored
// - immediate load updates running down counter at once
// - timeout load waits for count to zero
// - immediate match becomes active at once
// - timeout match buffered until count to zero
// - deferral applies only when counting down
// - wide full width match is 64 bits
// - running down counter reloads without waiting period end
module tmps_top (
  input wire logic pclk, // system clock, 10 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [tmps_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic cap_a_i, // capture pin, first half
  input wire logic cap_b_i, // capture pin, second half
  output logic [tmps_pkg::SYNC_W-1:0] sync_o, // restart pulses
  output logic match_a_o, // match pulse, first half
  output logic match_b_o, // match pulse, second half
  output logic timeout_a_o, // timeout pulse, first half
  output logic timeout_b_o, // timeout pulse, second half
  output logic pwm_a_o, // pwm waveform, first half
  output logic pwm_b_o // pwm waveform, second half
);
  typedef struct packed {
    logic [31:0] cfg; // control word
    logic [31:0] load_a; // load, low word in full width
    logic [31:0] load_b; // load, high word in wide full width
    logic [31:0] match_a; // match, low word
    logic [31:0] match_b; // match, high word
    logic [tmps_pkg::PS_W-1:0] psl_a; // prescale load
    logic [tmps_pkg::PS_W-1:0] psl_b;
    logic [tmps_pkg::PS_W-1:0] psm_a; // prescale match
    logic [tmps_pkg::PS_W-1:0] psm_b;
    logic [tmps_pkg::SYNC_W-1:0] sync; // restart pulses
    logic [31:0] prdata; // read data held for access phase
    logic pready; // ready in access phase
    logic pslverr; // error in access phase
    logic [2:0] cap_a; // pin sync chain, bit 0 first
    logic [2:0] cap_b;
    logic ld_wr_a; // load changed, pass to half
    logic ld_wr_b;
    logic mt_wr_a; // match changed, pass to half
    logic mt_wr_b;
  } tmps_top_s;
  tmps_top_s s, n;

  logic split; // two half-width timers
  tmps_pkg::tmps_mode_e mode_a; // first half mode
  tmps_pkg::tmps_mode_e mode_b; // second half mode
  logic up_a; // first half counts up
  logic up_b;
  logic run_a; // first half enabled
  logic run_b; // second half enabled
  logic wr_go; // write completes this edge
  logic rd_setup; // setup phase of an access
  logic rs_a; // restart first half
  logic rs_b; // restart second half
  logic [tmps_pkg::FULL_W-1:0] ld_val_a; // extended load values
  logic [tmps_pkg::FULL_W-1:0] ld_val_b;
  logic [tmps_pkg::FULL_W-1:0] mt_val_a; // extended match values
  logic [tmps_pkg::FULL_W-1:0] mt_val_b;
  logic [tmps_pkg::FULL_W-1:0] wmask_a; // counter width masks
  logic [tmps_pkg::FULL_W-1:0] cnt_a; // counter values
  logic [tmps_pkg::FULL_W-1:0] cnt_b;

  // prescaler sits in the low bits only for down counting one-shot and periodic timers
  function automatic logic ps_low(tmps_pkg::tmps_mode_e m, logic up);
    return !up && (m == tmps_pkg::MODE_ONESHOT ||
                   m == tmps_pkg::MODE_PERIODIC);
  endfunction

  // build the extended value the half counts or compares against
  function automatic logic [tmps_pkg::FULL_W-1:0] ext_join(
    logic sp, logic lsb, logic [31:0] lo, logic [31:0] hi,
    logic [tmps_pkg::PS_W-1:0] ps);
    logic [63:0] whole;
    whole = {hi, lo};
    if (!sp) begin
      // full width: prescaler unused, wide parts span both words
      return whole[tmps_pkg::FULL_W-1:0];
    end
    if (lsb) begin
      return tmps_pkg::FULL_W'({lo[tmps_pkg::HALF_W-1:0], ps});
    end
    return tmps_pkg::FULL_W'({ps, lo[tmps_pkg::HALF_W-1:0]});
  endfunction

  // decode of the control word
  assign split = s.cfg[tmps_pkg::CFG_SPLIT];
  assign mode_a = tmps_pkg::tmps_mode_e'(
    s.cfg[tmps_pkg::CFG_MODE_A +: tmps_pkg::MODE_W]);
  assign mode_b = tmps_pkg::tmps_mode_e'(
    s.cfg[tmps_pkg::CFG_MODE_B +: tmps_pkg::MODE_W]);
  assign up_a = s.cfg[tmps_pkg::CFG_UP_A];
  assign up_b = s.cfg[tmps_pkg::CFG_UP_B];
  assign run_a = s.cfg[tmps_pkg::CFG_EN_A];
  // the second half only exists as a timer when split
  assign run_b = s.cfg[tmps_pkg::CFG_EN_B] && split;
  assign wmask_a = split ? tmps_pkg::EXT_MASK : tmps_pkg::CNT_ALL;

  // extended values are rebuilt from the stored words each cycle
  assign ld_val_a = ext_join(split, ps_low(mode_a, up_a), s.load_a,
                             s.load_b, s.psl_a);
  assign ld_val_b = ext_join(1'b1, ps_low(mode_b, up_b), s.load_b,
                             s.load_b, s.psl_b);
  assign mt_val_a = ext_join(split, ps_low(mode_a, up_a), s.match_a,
                             s.match_b, s.psm_a);
  assign mt_val_b = ext_join(1'b1, ps_low(mode_b, up_b), s.match_b,
                             s.match_b, s.psm_b);

  // own halves restart from the same registered pulse sent outward
  assign rs_a = s.sync[tmps_pkg::NARROW0_FIRST_HALF_SYNC_SELECT];
  assign rs_b = s.sync[tmps_pkg::NARROW0_SECOND_HALF_SYNC_SELECT] &&
                split;

  // apb phases; a write lands only at the ready edge
  assign rd_setup = psel && !penable;
  assign wr_go = psel && penable && s.pready && pwrite && !s.pslverr;

  // next state: bus slave, registers and pin synchronisers
  always_comb begin
    n = s;
    // two flops before the edge detector reads the pins
    n.cap_a = {s.cap_a[1:0], cap_a_i};
    n.cap_b = {s.cap_b[1:0], cap_b_i};
    // change pulses last one cycle
    n.ld_wr_a = 1'b0;
    n.ld_wr_b = 1'b0;
    n.mt_wr_a = 1'b0;
    n.mt_wr_b = 1'b0;
    n.sync = '0;
    // answer is prepared in setup and shown in the access phase
    n.pready = rd_setup;
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    if (rd_setup) begin
      unique case (paddr)
        tmps_pkg::OFF_CFG: n.prdata = s.cfg;
        tmps_pkg::OFF_LOAD_A: n.prdata = s.load_a;
        tmps_pkg::OFF_LOAD_B: n.prdata = s.load_b;
        tmps_pkg::OFF_MATCH_A: n.prdata = s.match_a;
        tmps_pkg::OFF_MATCH_B: n.prdata = s.match_b;
        tmps_pkg::OFF_PSL_A: n.prdata = 32'(s.psl_a);
        tmps_pkg::OFF_PSL_B: n.prdata = 32'(s.psl_b);
        tmps_pkg::OFF_PSM_A: n.prdata = 32'(s.psm_a);
        tmps_pkg::OFF_PSM_B: n.prdata = 32'(s.psm_b);
        tmps_pkg::OFF_VAL_A: n.prdata = cnt_a[31:0];
        tmps_pkg::OFF_VAL_B: n.prdata = cnt_b[31:0];
        tmps_pkg::OFF_VAL_AH: n.prdata = 32'(cnt_a >> 32);
        tmps_pkg::OFF_SYNC: n.prdata = 32'h0000_0000; // write only
        tmps_pkg::OFF_STAT: n.prdata = 32'({split, pwm_b_o, pwm_a_o});
        default: n.pslverr = 1'b1; // unmapped address
      endcase
      if (pwrite) begin
        n.prdata = 32'h0000_0000;
      end
    end
    if (wr_go) begin
      unique case (paddr)
        tmps_pkg::OFF_CFG: n.cfg = pwdata;
        tmps_pkg::OFF_LOAD_A: begin
          n.load_a = pwdata;
          n.ld_wr_a = 1'b1;
        end
        tmps_pkg::OFF_LOAD_B: begin
          n.load_b = pwdata;
          n.ld_wr_b = 1'b1;
          n.ld_wr_a = !split; // high word of a wide full load
        end
        tmps_pkg::OFF_MATCH_A: begin
          n.match_a = pwdata;
          n.mt_wr_a = 1'b1;
        end
        tmps_pkg::OFF_MATCH_B: begin
          n.match_b = pwdata;
          n.mt_wr_b = 1'b1;
          n.mt_wr_a = !split;
        end
        tmps_pkg::OFF_PSL_A: begin
          n.psl_a = pwdata[tmps_pkg::PS_W-1:0];
          n.ld_wr_a = 1'b1;
        end
        tmps_pkg::OFF_PSL_B: begin
          n.psl_b = pwdata[tmps_pkg::PS_W-1:0];
          n.ld_wr_b = 1'b1;
        end
        tmps_pkg::OFF_PSM_A: begin
          n.psm_a = pwdata[tmps_pkg::PS_W-1:0];
          n.mt_wr_a = 1'b1;
        end
        tmps_pkg::OFF_PSM_B: begin
          n.psm_b = pwdata[tmps_pkg::PS_W-1:0];
          n.mt_wr_b = 1'b1;
        end
        // only the first module owns this register
        tmps_pkg::OFF_SYNC: n.sync = pwdata[tmps_pkg::SYNC_W-1:0];
        default: ; // read-only registers ignore writes
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.cfg <= tmps_pkg::CFG_RST;
    end else begin
      s <= n;
    end
  end

  // first half, also the full-width timer
  tmps_half u_half_a (
    .pclk(pclk),
    .presetn(presetn),
    .run(run_a),
    .up_cfg(up_a),
    .mode(mode_a),
    .rtc_en(s.cfg[tmps_pkg::CFG_RTC_EN]),
    .cap_edge(s.cap_a[1] && !s.cap_a[2]),
    .restart(rs_a),
    .defer_load(s.cfg[tmps_pkg::CFG_LDT_A] !=
                tmps_pkg::RELOAD_APPLY_NOW),
    .defer_match(s.cfg[tmps_pkg::CFG_MTT_A] !=
                 tmps_pkg::COMPARE_APPLY_NOW),
    .ld_wr(s.ld_wr_a),
    .ld_val(ld_val_a),
    .mt_wr(s.mt_wr_a),
    .mt_val(mt_val_a),
    .wmask(wmask_a),
    .count_o(cnt_a),
    .match_o(match_a_o),
    .tmo_o(timeout_a_o),
    .pwm_o(pwm_a_o)
  );

  // second half, idle unless split
  tmps_half u_half_b (
    .pclk(pclk),
    .presetn(presetn),
    .run(run_b),
    .up_cfg(up_b),
    .mode(mode_b),
    .rtc_en(s.cfg[tmps_pkg::CFG_RTC_EN]),
    .cap_edge(s.cap_b[1] && !s.cap_b[2]),
    .restart(rs_b),
    .defer_load(s.cfg[tmps_pkg::CFG_LDT_B] !=
                tmps_pkg::RELOAD_APPLY_NOW),
    .defer_match(s.cfg[tmps_pkg::CFG_MTT_B] !=
                 tmps_pkg::COMPARE_APPLY_NOW),
    .ld_wr(s.ld_wr_b),
    .ld_val(ld_val_b),
    .mt_wr(s.mt_wr_b),
    .mt_val(mt_val_b),
    .wmask(tmps_pkg::EXT_MASK),
    .count_o(cnt_b),
    .match_o(match_b_o),
    .tmo_o(timeout_b_o),
    .pwm_o(pwm_b_o)
  );

  // bus and sync outputs straight from flops
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign sync_o = s.sync;

  sequence s_sync_req;
    wr_go && paddr == tmps_pkg::OFF_SYNC &&
      pwdata[tmps_pkg::NARROW0_FIRST_HALF_SYNC_SELECT];
  endsequence
  property p_sync_a;
    @(posedge pclk) disable iff (!presetn)
    s_sync_req |=> rs_a && sync_o[tmps_pkg::NARROW0_FIRST_HALF_SYNC_SELECT];
  endproperty
  a_sync_a: assert property (p_sync_a)
    else $error("sync request did not restart first half");
  // in full width only a load write may move the idle second half
  property p_sync_b;
    @(posedge pclk) disable iff (!presetn)
    (!split && !s.ld_wr_b) |=> $stable(cnt_b);
  endproperty
  a_sync_b: assert property (p_sync_b)
    else $error("second half restarted in full width");
  property p_full_load;
    @(posedge pclk) disable iff (!presetn)
    !split |-> ld_val_a == tmps_pkg::FULL_W'({s.load_b, s.load_a});
  endproperty
  a_full_load: assert property (p_full_load)
    else $error("prescaler leaked into full width load");
endmodule

// ---- tb/tmps_top_bench.sv ----
`timescale 1ns/1ns
module tmps_top_bench;
  logic pclk = 1'b0; // 100 ns bus clock
  logic presetn = 1'b0; // reset, active low
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb request
  logic [7:0] paddr = 8'h00; // apb byte address
  logic [31:0] pwdata = 32'h0000_0000; // apb write data
  logic cap_a_i = 1'b0; // capture pin, first half
  logic [31:0] prdata, rd, r0; // read data, last read, scratch
  logic pready, pslverr, err, match_a_o, timeout_a_o, pwm_a_o; // answers
  logic match_b_o, timeout_b_o, pwm_b_o; // second half answers
  logic [23:0] sync_o, so; // restart pulses, copy after a write
  logic [31:0] seed = 32'h334e_6cf4; // xorshift state, fixed start
  logic [31:0] per; // periodic down, first half enabled
  int num_errors, total_checks, cyc, nm, nw, nt, c0, c1, m0, m1, w0, w1;
  int pb, mb, tb, p0, m2, t0; // second half counts and snapshots

  tmps_top tmps_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_a_i(cap_a_i),
    .cap_b_i(1'b0), .sync_o(sync_o), .match_a_o(match_a_o),
    .match_b_o(match_b_o), .timeout_a_o(timeout_a_o),
    .timeout_b_o(timeout_b_o), .pwm_a_o(pwm_a_o), .pwm_b_o(pwm_b_o));

  initial forever #50 pclk = ~pclk;

  // count events of both halves, snapshot the first half's at each of its timeouts
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    nm <= nm + int'(match_a_o === 1'b1);
    nw <= nw + int'(pwm_a_o === 1'b1);
    pb <= pb + int'(pwm_b_o === 1'b1);
    mb <= mb + int'(match_b_o === 1'b1);
    tb <= tb + int'(timeout_b_o === 1'b1);
    if (timeout_a_o === 1'b1) begin
      nt <= nt + 1;
      {c0, c1, m0, m1, w0, w1} <= {c1, cyc, m1, nm, w1, nw};
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // control word: mode field of the first half plus its enable
  function automatic logic [31:0] cf(tmps_pkg::tmps_mode_e m);
    return (32'h0000_0001 << tmps_pkg::CFG_EN_A) |
      (32'(m) << tmps_pkg::CFG_MODE_A);
  endfunction

  function automatic logic [31:0] bt(int b);
    return 32'h0000_0001 << b;
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one apb transfer; request held until pready seen, then an idle cycle
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is looked at on the edge that ends each access cycle
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        num_errors++;
        end_of_test();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    so = sync_o; // restart pulses stand in this cycle only
  endtask

  // wait for the next timeout pulse, bounded so a dead counter ends the run
  task automatic wtmo();
    int n0;
    n0 = nt;
    repeat (9000) if (nt == n0) @(posedge pclk);
    if (nt == n0) begin
      num_errors++;
      end_of_test();
    end
  endtask

  // load and match land while stopped, so immediate update is certain
  task automatic setup(logic [31:0] c, ld, mt);
    apb(1'b1, tmps_pkg::OFF_CFG, 32'h0000_0000);
    apb(1'b1, tmps_pkg::OFF_LOAD_A, ld);
    apb(1'b1, tmps_pkg::OFF_MATCH_A, mt);
    apb(1'b1, tmps_pkg::OFF_CFG, c);
  endtask

  // one whole period: its length, pwm high cycles and match pulses
  task automatic meas(int p, int h, int m);
    wtmo();
    wtmo();
    check("period", c1 - c0, p);
    check("pwm high", w1 - w0, h);
    if (m >= 0)
      check("matches", m1 - m0, m);
  endtask

  // new match written once the count has passed the old one (down) or the new one (up); pulses up to the timeout
  task automatic late(logic [31:0] c, old, nw_m, int k, exp);
    setup(c, 300, old);
    wtmo();
    repeat (k) @(posedge pclk);
    apb(1'b1, tmps_pkg::OFF_MATCH_A, nw_m);
    r0 = nm;
    wtmo();
    check("late match", nm - r0, exp);
    meas(301, 0, 1);
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, tmps_pkg::OFF_CFG, 32'h0000_0000);
    check("cfg reset", rd, tmps_pkg::CFG_RST);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    check("unmapped", err, 1'b1);
    // prescaler values must be ignored in full width
    per = cf(tmps_pkg::MODE_PERIODIC);
    apb(1'b1, tmps_pkg::OFF_PSL_A, 32'h0000_0005);
    apb(1'b1, tmps_pkg::OFF_PSM_A, 32'h0000_0002);
    setup(per | bt(tmps_pkg::CFG_RTC_EN), 16, 4);
    meas(17, 0, 1);
    // split: down count puts the prescaler below the counter bits
    setup(per | bt(tmps_pkg::CFG_SPLIT), 3, 1);
    // extended words latch on a write, so repeat them once split
    apb(1'b1, tmps_pkg::OFF_PSL_A, 32'h0000_0005);
    apb(1'b1, tmps_pkg::OFF_PSM_A, 32'h0000_0002);
    meas(774, 0, 1);
    apb(1'b1, tmps_pkg::OFF_PSL_A, 32'h0000_0000);
    apb(1'b1, tmps_pkg::OFF_PSM_A, 32'h0000_0000);
    // split second half as pwm: period 10, 6 high cycles, 1 match each
    apb(1'b1, tmps_pkg::OFF_CFG, bt(tmps_pkg::CFG_SPLIT) |
      bt(tmps_pkg::CFG_EN_B) |
      (32'(tmps_pkg::MODE_PWM) << tmps_pkg::CFG_MODE_B));
    apb(1'b1, tmps_pkg::OFF_LOAD_B, 9);
    apb(1'b1, tmps_pkg::OFF_MATCH_B, 3);
    repeat (20) @(posedge pclk);
    {p0, m2, t0} = {pb, mb, tb};
    repeat (100) @(posedge pclk);
    check("pwm b high", pb - p0, 60);
    check("match b", mb - m2, 10);
    check("timeout b", tb - t0, 10);
    // pwm duty from match, zero as the corner case
    for (int i = 0; i < 3; i++) begin
      r0 = (i == 0) ? 32'h0000_0000 : rnd() % 100;
      setup(cf(tmps_pkg::MODE_PWM), 100, r0);
      meas(101, 100 - r0, -1);
    end
    // load deferred to the timeout, then applied there
    setup(per | bt(tmps_pkg::CFG_LDT_A), 40, 0);
    meas(41, 0, -1);
    apb(1'b1, tmps_pkg::OFF_LOAD_A, 200);
    apb(1'b0, tmps_pkg::OFF_VAL_A, 0);
    check("held load", rd <= 40, 1'b1);
    meas(201, 0, -1);
    // immediate load reaches the running counter
    setup(per, 3000, 0);
    repeat (40) @(posedge pclk);
    apb(1'b1, tmps_pkg::OFF_LOAD_A, 500);
    apb(1'b0, tmps_pkg::OFF_VAL_A, 0);
    check("reload now", rd <= 500 && rd > 490, 1'b1);
    late(per | bt(tmps_pkg::CFG_MTT_A), 250, 50, 100, 0);
    late(per, 250, 50, 100, 1);
    late(per | bt(tmps_pkg::CFG_MTT_A) | bt(tmps_pkg::CFG_UP_A),
      290, 100, 150, 0);
    // rtc counts only with its enable
    setup(cf(tmps_pkg::MODE_RTC), 32'hFFFF_0000, 0);
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, tmps_pkg::OFF_VAL_A, 0);
      r0 = rd;
      apb(1'b0, tmps_pkg::OFF_VAL_A, 0);
      check("rtc step", rd - r0, 3 * i);
      apb(1'b1, tmps_pkg::OFF_CFG,
        cf(tmps_pkg::MODE_RTC) | bt(tmps_pkg::CFG_RTC_EN));
    end
    // capture edges counted up from a sync restart to the match
    setup(cf(tmps_pkg::MODE_CAPCNT) | bt(tmps_pkg::CFG_UP_A), 32'hFFFF, 3);
    apb(1'b1, tmps_pkg::OFF_SYNC, 32'h0000_0001);
    r0 = nm;
    for (int i = 1; i <= 3; i++) begin
      cap_a_i <= 1'b1;
      repeat (8 + rnd() % 8) @(posedge pclk);
      cap_a_i <= 1'b0;
      repeat (8 + rnd() % 8) @(posedge pclk);
      check("edge match", nm - r0, i / 3);
    end
    // random sync sets: pulses out, own counter restarted
    setup(per, 1000, 0);
    for (int i = 0; i < 3; i++) begin
      repeat (200) @(posedge pclk);
      r0 = rnd() | 32'h0000_0001;
      apb(1'b1, tmps_pkg::OFF_SYNC, r0);
      check("sync out", so, r0[23:0]);
      apb(1'b0, tmps_pkg::OFF_VAL_A, 0);
      check("restart", rd > 990 && rd <= 1000, 1'b1);
    end
    // one-shot: one match and one timeout, then the count parks
    setup(cf(tmps_pkg::MODE_ONESHOT), 20, 5);
    {m2, t0} = {nm, nt};
    wtmo();
    repeat (60) @(posedge pclk);
    check("one-shot match", nm - m2, 1);
    check("one-shot end", nt - t0, 1);
    end_of_test();
  end
endmodule
